// file: core/boot_params.svh
`ifndef BOOT_PARAMS_SVH
`define BOOT_PARAMS_SVH

`define SEC_BOOT_BIT 5
`define BYPASS_WORD 32'h0D15_AB1E
`define CRC_POLY 32'hEDB8_8320
`define CRC_INIT 32'hFFFF_FFFF
`define RAM_BASE 32'h0000_0000
`define OTP_AW 11
`define OTP_BOOT_ADDR 11'h000
`define FLASH_READ_CMD 8'h03
`define FLASH_START_ADDR 24'h00_0000
`define CMD_BITS 6'h20
`define CLK_PERIOD_NS 4
`define RESET_SEQ_NS 15000
`define SEQ_CYCLES ((`RESET_SEQ_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define SPI_HALF 4

`endif

// file: core/boot_pkg.sv
package boot_pkg;

    typedef struct packed {
        logic cs_n;
        logic sclk;
        logic mosi;
    } flash_pins_t;

    typedef struct packed {
        logic we;
        logic [31:0] addr;
        logic [31:0] data;
    } ram_wr_t;

    typedef enum logic [2:0] {
        S_HOLD,
        S_SEQ,
        S_LEN,
        S_PROG,
        S_CRC,
        S_CHECK,
        S_RUN,
        S_ERR
    } boot_state_t;

endpackage

// file: core/spi_byte_reader.sv
`timescale 1ns/10ps
`include "boot_params.svh"

module spi_byte_reader #(
    parameter int unsigned SPI_HALF = `SPI_HALF
) (
    input wire logic ref_clk_i,
    input wire logic rst_i,
    input wire logic en_i,
    input wire logic miso_i,
    output boot_pkg::flash_pins_t pins_o,
    output logic byte_vld_o,
    output logic [7:0] byte_o
);
    import boot_pkg::*;

    localparam int DW = $clog2(SPI_HALF + 1);

    logic [DW-1:0] div_q, div_d;
    logic sclk_q, sclk_d;
    logic cs_n_q, cs_n_d;
    logic [31:0] out_q, out_d;
    logic [5:0] cmd_left_q, cmd_left_d;
    logic [7:0] rx_q, rx_d;
    logic [2:0] rx_cnt_q, rx_cnt_d;
    logic vld_q, vld_d;
    logic [7:0] byte_q, byte_d;
    logic tick;

    assign tick = (div_q == DW'(SPI_HALF - 1));

    always_comb begin
        div_d = tick ? '0 : div_q + 1'b1;
        sclk_d = sclk_q;
        cs_n_d = 1'b0;
        out_d = out_q;
        cmd_left_d = cmd_left_q;
        rx_d = rx_q;
        rx_cnt_d = rx_cnt_q;
        vld_d = 1'b0;
        byte_d = byte_q;
        if (!en_i) begin
            // Deselect also reloads the read command for the next session
            div_d = '0;
            sclk_d = 1'b0;
            cs_n_d = 1'b1;
            out_d = {`FLASH_READ_CMD, `FLASH_START_ADDR};
            cmd_left_d = `CMD_BITS;
            rx_cnt_d = '0;
        end else if (tick) begin
            sclk_d = ~sclk_q;
            if (sclk_q) begin
                if (cmd_left_q != '0) begin
                    cmd_left_d = cmd_left_q - 1'b1;
                    out_d = {out_q[30:0], 1'b0};
                end else begin
                    // Flash launches on falling edge, so sample just before the next one
                    rx_d = {rx_q[6:0], miso_i};
                    rx_cnt_d = rx_cnt_q + 1'b1;
                    if (rx_cnt_q == 3'h7) begin
                        vld_d = 1'b1;
                        byte_d = {rx_q[6:0], miso_i};
                    end
                end
            end
        end
    end

    always_ff @(posedge ref_clk_i) begin
        if (rst_i) begin
            div_q <= '0;
            sclk_q <= 1'b0;
            cs_n_q <= 1'b1;
            out_q <= '0;
            cmd_left_q <= '0;
            rx_q <= '0;
            rx_cnt_q <= '0;
            vld_q <= 1'b0;
            byte_q <= '0;
        end else begin
            div_q <= div_d;
            sclk_q <= sclk_d;
            cs_n_q <= cs_n_d;
            out_q <= out_d;
            cmd_left_q <= cmd_left_d;
            rx_q <= rx_d;
            rx_cnt_q <= rx_cnt_d;
            vld_q <= vld_d;
            byte_q <= byte_d;
        end
    end

    assign pins_o = '{cs_n: cs_n_q, sclk: sclk_q, mosi: out_q[31]};
    assign byte_vld_o = vld_q;
    assign byte_o = byte_q;

endmodule

// file: core/boot_image_loader.sv
`timescale 1ns/10ps
`include "boot_params.svh"

// Functional notes
// R01: Core stays in reset while the active-low reset pin is low.
// R02: All I/O pull-downs are enabled while in reset.
// R03: Internal reset sequence delays boot 15 us after reset release.
// R04: Security bit 5 selects OTP as boot source, else serial flash.
// R05: Serial flash is read over the tile 0 port pins.
// R06: Image starts with a 32-bit word count, then four bytes per word.
// R07: Check word after program; value 0x0D15AB1E skips CRC checking.
// R08: Length and check words arrive least significant byte first.
// R09: Program goes to lowest RAM address; execution starts there.
// R10: CRC covers length bytes and program bytes, not the check word.
// R11: CRC is reflected CRC-32, polynomial 0xEDB88320, bytewise.
// R12: CRC starts at all ones; final residue is inverted for compare.
// R13: Secure boot reads OTP from address 0, bypassing boot ROM.
// R14: CRC mismatch blocks program start and raises boot error.
module boot_image_loader #(
    parameter int unsigned SEQ_CYCLES = `SEQ_CYCLES,
    parameter int unsigned SPI_HALF = `SPI_HALF
) (
    input wire logic ref_clk_i,
    input wire logic rst_i,
    input wire logic rst_pin_n_i,
    input wire logic [31:0] security_word_i,
    output logic gpio_pull_down_o,
    output boot_pkg::flash_pins_t flash_o,
    input wire logic flash_miso_i,
    output logic otp_rd_o,
    output logic [`OTP_AW-1:0] otp_addr_o,
    input wire logic [31:0] otp_data_i,
    output boot_pkg::ram_wr_t ram_o,
    output logic run_o,
    output logic [31:0] start_addr_o,
    output logic boot_error_o
);
    import boot_pkg::*;

    localparam int SW = $clog2(SEQ_CYCLES + 1);

    function automatic logic [31:0] crc_byte(input logic [31:0] c, input logic [7:0] b);
        logic [31:0] r;
        r = c ^ {24'h00_0000, b};
        for (int i = 0; i < 8; i++) begin
            r = r[0] ? ((r >> 1) ^ `CRC_POLY) : (r >> 1);
        end
        return r;
    endfunction

    logic rst_s1_q, rst_s2_q, miso_s1_q, miso_s2_q;
    logic hold;

    always_ff @(posedge ref_clk_i) begin
        if (rst_i) begin
            rst_s1_q <= 1'b0;
            rst_s2_q <= 1'b0;
            miso_s1_q <= 1'b0;
            miso_s2_q <= 1'b0;
        end else begin
            rst_s1_q <= rst_pin_n_i;
            rst_s2_q <= rst_s1_q;
            miso_s1_q <= flash_miso_i;
            miso_s2_q <= miso_s1_q;
        end
    end

    assign hold = rst_i | ~rst_s2_q; // R01

    boot_state_t state_q, state_d;
    logic [SW-1:0] seq_cnt_q, seq_cnt_d;
    logic otp_sel_q, otp_sel_d;
    logic [31:0] word_q, word_d, len_q, len_d, widx_q, widx_d, crc_q, crc_d;
    logic [1:0] bcnt_q, bcnt_d;
    // Remembers the sequencer state so the first fetch cycle can be recognised
    logic was_seq_q, was_seq_d;
    ram_wr_t ram_q, ram_d;
    logic fetch, spi_vld, b_vld;
    logic [7:0] spi_byte, b_dat;

    // OTP byte source: one word read, then four bytes low byte first
    logic otp_wait_q, otp_wait_d;
    logic [2:0] otp_left_q, otp_left_d;
    logic [31:0] otp_word_q, otp_word_d;
    logic [`OTP_AW-1:0] otp_addr_q, otp_addr_d;
    logic otp_rd;

    assign fetch = (state_q == S_LEN) || (state_q == S_PROG) || (state_q == S_CRC);
    assign otp_rd = fetch && otp_sel_q && !otp_wait_q && (otp_left_q == '0); // R04

    always_comb begin
        otp_wait_d = otp_rd;
        otp_left_d = otp_left_q;
        otp_word_d = otp_word_q;
        otp_addr_d = otp_addr_q;
        if (state_q == S_SEQ) begin
            otp_addr_d = `OTP_BOOT_ADDR; // R13
            otp_left_d = '0;
        end else if (otp_wait_q) begin
            otp_word_d = otp_data_i;
            otp_left_d = 3'h4;
            otp_addr_d = otp_addr_q + 1'b1;
        end else if (otp_left_q != '0) begin
            otp_word_d = {8'h00, otp_word_q[31:8]}; // R08
            otp_left_d = otp_left_q - 1'b1;
        end
    end

    always_ff @(posedge ref_clk_i) begin
        if (hold) begin
            otp_wait_q <= 1'b0;
            otp_left_q <= '0;
            otp_word_q <= '0;
            otp_addr_q <= `OTP_BOOT_ADDR;
        end else begin
            otp_wait_q <= otp_wait_d;
            otp_left_q <= otp_left_d;
            otp_word_q <= otp_word_d;
            otp_addr_q <= otp_addr_d;
        end
    end

    spi_byte_reader #(
        .SPI_HALF(SPI_HALF)
    ) u_flash (
        .ref_clk_i(ref_clk_i),
        .rst_i(hold),
        .en_i(fetch && !otp_sel_q), // R05
        .miso_i(miso_s2_q),
        .pins_o(flash_o),
        .byte_vld_o(spi_vld),
        .byte_o(spi_byte)
    );

    assign b_vld = otp_sel_q ? (otp_left_q != '0) && fetch : spi_vld; // R04
    assign b_dat = otp_sel_q ? otp_word_q[7:0] : spi_byte;

    always_comb begin
        state_d = state_q;
        seq_cnt_d = seq_cnt_q;
        otp_sel_d = otp_sel_q;
        word_d = word_q;
        len_d = len_q;
        widx_d = widx_q;
        crc_d = crc_q;
        bcnt_d = bcnt_q;
        was_seq_d = (state_q == S_SEQ);
        ram_d = ram_q;
        ram_d.we = 1'b0;
        if (fetch && b_vld) begin
            word_d = {b_dat, word_q[31:8]}; // R08
            bcnt_d = bcnt_q + 1'b1;
            if (state_q != S_CRC) begin
                crc_d = crc_byte(crc_q, b_dat); // R10 R11
            end
        end
        unique case (state_q)
            S_HOLD: begin
                seq_cnt_d = '0;
                state_d = S_SEQ;
            end
            S_SEQ: begin
                seq_cnt_d = seq_cnt_q + 1'b1;
                if (seq_cnt_q == SW'(SEQ_CYCLES - 1)) begin // R03
                    otp_sel_d = security_word_i[`SEC_BOOT_BIT]; // R04
                    crc_d = `CRC_INIT; // R12
                    bcnt_d = '0;
                    state_d = S_LEN;
                end
            end
            S_LEN: begin
                if (b_vld && bcnt_q == 2'h3) begin
                    len_d = word_d; // R06
                    widx_d = '0;
                    state_d = (word_d == '0) ? S_CRC : S_PROG;
                end
            end
            S_PROG: begin
                if (b_vld && bcnt_q == 2'h3) begin
                    ram_d.we = 1'b1;
                    ram_d.addr = `RAM_BASE + widx_q; // R09
                    ram_d.data = word_d;
                    widx_d = widx_q + 1'b1;
                    if (widx_q == len_q - 1'b1) begin // R06
                        state_d = S_CRC;
                    end
                end
            end
            S_CRC: begin
                if (b_vld && bcnt_q == 2'h3) begin
                    state_d = S_CHECK;
                end
            end
            S_CHECK: begin
                // Bypass is honoured even if the residue would also have matched
                if (word_q == `BYPASS_WORD || word_q == ~crc_q) begin // R07 R12
                    state_d = S_RUN;
                end else begin
                    state_d = S_ERR; // R14
                end
            end
            S_RUN: state_d = S_RUN;
            S_ERR: state_d = S_ERR;
        endcase
    end

    always_ff @(posedge ref_clk_i) begin
        if (hold) begin
            state_q <= S_HOLD; // R01
            seq_cnt_q <= '0;
            otp_sel_q <= 1'b0;
            word_q <= '0;
            len_q <= '0;
            widx_q <= '0;
            crc_q <= `CRC_INIT;
            bcnt_q <= '0;
            was_seq_q <= 1'b0;
            ram_q <= '0;
        end else begin
            state_q <= state_d;
            seq_cnt_q <= seq_cnt_d;
            otp_sel_q <= otp_sel_d;
            word_q <= word_d;
            len_q <= len_d;
            widx_q <= widx_d;
            crc_q <= crc_d;
            bcnt_q <= bcnt_d;
            was_seq_q <= was_seq_d;
            ram_q <= ram_d;
        end
    end

    assign gpio_pull_down_o = (state_q == S_HOLD); // R02
    assign otp_rd_o = otp_rd;
    assign otp_addr_o = otp_addr_q;
    assign ram_o = ram_q;
    assign run_o = (state_q == S_RUN); // R09 R14
    assign start_addr_o = `RAM_BASE; // R09
    assign boot_error_o = (state_q == S_ERR); // R14

    logic enter_len;
    assign enter_len = (state_q == S_LEN) && was_seq_q;

    a_hold_pulldown: assert property (@(posedge ref_clk_i) hold |=> gpio_pull_down_o) // R02
        else $error("pull-down not active after reset hold");
    a_hold_norun: assert property (@(posedge ref_clk_i) hold |=> !run_o && !ram_o.we) // R01
        else $error("activity during reset hold");
    a_seq_delay: assert property (@(posedge ref_clk_i) disable iff (hold)
        enter_len |-> $past(seq_cnt_q) == SW'(SEQ_CYCLES - 1)) // R03
        else $error("boot started before reset sequence ended");
    a_src_flash: assert property (@(posedge ref_clk_i) disable iff (hold)
        (fetch && otp_sel_q) |-> flash_o.cs_n) // R04
        else $error("flash selected during OTP boot");
    a_src_otp: assert property (@(posedge ref_clk_i) disable iff (hold)
        !otp_sel_q |-> !otp_rd_o) // R04
        else $error("OTP read during flash boot");
    a_otp_start: assert property (@(posedge ref_clk_i) disable iff (hold)
        enter_len |-> otp_addr_q == `OTP_BOOT_ADDR && crc_q == `CRC_INIT) // R12 R13
        else $error("boot did not start at OTP address zero with CRC all ones");
    a_first_word: assert property (@(posedge ref_clk_i) disable iff (hold)
        (state_q == S_PROG && b_vld && bcnt_q == 2'h3 && widx_q == '0)
        |=> ram_o.we && ram_o.addr == `RAM_BASE) // R09
        else $error("first program word not at lowest RAM address");
    a_len_msb: assert property (@(posedge ref_clk_i) disable iff (hold)
        (state_q == S_LEN && b_vld && bcnt_q == 2'h3) |=> len_q[31:24] == $past(b_dat)) // R08
        else $error("length word not assembled low byte first");
    a_crc_frozen: assert property (@(posedge ref_clk_i) disable iff (hold)
        state_q == S_CRC |=> crc_q == $past(crc_q)) // R10
        else $error("check word entered the CRC");
    a_bypass_run: assert property (@(posedge ref_clk_i) disable iff (hold)
        (state_q == S_CHECK && word_q == `BYPASS_WORD) |=> run_o) // R07
        else $error("bypass word did not start program");
    a_crc_error: assert property (@(posedge ref_clk_i) disable iff (hold)
        (state_q == S_CHECK && word_q != `BYPASS_WORD && word_q != ~crc_q)
        |=> boot_error_o ##1 (boot_error_o && !run_o)) // R14
        else $error("CRC mismatch did not raise boot error");

    c_run_bypass: cover property (@(posedge ref_clk_i) disable iff (hold)
        state_q == S_CHECK && word_q == `BYPASS_WORD);
    c_run_crc: cover property (@(posedge ref_clk_i) disable iff (hold)
        state_q == S_CHECK && word_q == ~crc_q);
    c_error: cover property (@(posedge ref_clk_i) disable iff (hold) $rose(boot_error_o));
    c_otp_boot: cover property (@(posedge ref_clk_i) disable iff (hold) run_o && otp_sel_q);

endmodule

// file: dv/boot_mem_model.sv
`timescale 1ns/10ps
`include "boot_params.svh"

module boot_mem_model (
    input wire logic ref_clk_i,
    input wire logic rst_i,
    input wire boot_pkg::flash_pins_t flash_i,
    output logic miso_o,
    input wire logic otp_rd_i,
    input wire logic [`OTP_AW-1:0] otp_addr_i,
    output logic [31:0] otp_data_o,
    output logic [31:0] cmd_o,
    output logic [`OTP_AW-1:0] otp_first_o,
    output int otp_reads_o
);
    import boot_pkg::*;
    logic [7:0] mem [0:63];
    logic sclk_p;
    int cnt;
    int idx;

    initial begin
        miso_o = 1'b0;
        otp_data_o = 32'h0000_0000;
        cmd_o = 32'h0000_0000;
        otp_first_o = '1;
        otp_reads_o = 0;
        sclk_p = 1'b0;
        cnt = 0;
    end

    // Flash edges are seen one reference clock late; the loader's sync margin absorbs it
    always @(posedge ref_clk_i) begin
        sclk_p <= flash_i.sclk;
        if (flash_i.cs_n) begin
            // Deselected: the line wanders so a stale bit cannot pass for data
            miso_o <= ~miso_o;
            cnt <= 0;
        end else if (flash_i.sclk && !sclk_p) begin
            if (cnt < 32) begin
                cmd_o <= {cmd_o[30:0], flash_i.mosi};
            end
            cnt <= cnt + 1;
        end else if (!flash_i.sclk && sclk_p) begin
            if (cnt < 32) begin
                miso_o <= ~miso_o;
            end else begin
                miso_o <= mem[((cnt - 32) >> 3) % 64][7 - ((cnt - 32) % 8)];
            end
        end
    end

    // Row data stands for one cycle only, then changes every cycle
    always @(posedge ref_clk_i) begin
        if (rst_i) begin
            otp_reads_o <= 0;
        end else if (otp_rd_i) begin
            idx = int'(otp_addr_i) * 4;
            otp_data_o <= {mem[(idx + 3) % 64], mem[(idx + 2) % 64],
                           mem[(idx + 1) % 64], mem[idx % 64]};
            if (otp_reads_o == 0) begin
                otp_first_o <= otp_addr_i;
            end
            otp_reads_o <= otp_reads_o + 1;
        end else begin
            otp_data_o <= ~otp_data_o;
        end
    end
endmodule

// file: dv/tb_boot_image_loader.sv
`timescale 1ns/10ps
`include "boot_params.svh"

module tb_boot_image_loader;
    import boot_pkg::*;
    localparam int unsigned SEQ = 20;
    logic ref_clk_i, rst_i, rst_pin_n_i, flash_miso_i, gpio_pull_down_o, otp_rd_o, run_o;
    logic boot_error_o, cs_low;
    logic [31:0] security_word_i, otp_data_i, start_addr_o, cmd;
    logic [`OTP_AW-1:0] otp_addr_o, otp_first;
    flash_pins_t flash_o;
    ram_wr_t ram_o;
    int otp_reads, mismatches, samples_checked, n_wr;
    logic [31:0] prog [0:15];
    logic [31:0] wr_addr [0:15];
    logic [31:0] wr_data [0:15];

    initial begin
        ref_clk_i = 1'b0;
        forever #2 ref_clk_i = ~ref_clk_i;
    end

    boot_image_loader #(.SEQ_CYCLES(SEQ), .SPI_HALF(4)) i_boot_image_loader (
        .ref_clk_i(ref_clk_i), .rst_i(rst_i), .rst_pin_n_i(rst_pin_n_i),
        .security_word_i(security_word_i), .gpio_pull_down_o(gpio_pull_down_o),
        .flash_o(flash_o), .flash_miso_i(flash_miso_i), .otp_rd_o(otp_rd_o),
        .otp_addr_o(otp_addr_o), .otp_data_i(otp_data_i), .ram_o(ram_o), .run_o(run_o),
        .start_addr_o(start_addr_o), .boot_error_o(boot_error_o));

    boot_mem_model i_boot_mem_model (
        .ref_clk_i(ref_clk_i), .rst_i(rst_i), .flash_i(flash_o), .miso_o(flash_miso_i),
        .otp_rd_i(otp_rd_o), .otp_addr_i(otp_addr_o), .otp_data_o(otp_data_i),
        .cmd_o(cmd), .otp_first_o(otp_first), .otp_reads_o(otp_reads));

    always @(posedge ref_clk_i) begin
        if (rst_i) begin
            n_wr <= 0;
            cs_low <= 1'b0;
        end else begin
            if (ram_o.we === 1'b1 && n_wr < 16) begin
                wr_addr[n_wr] <= ram_o.addr;
                wr_data[n_wr] <= ram_o.data;
                n_wr <= n_wr + 1;
            end
            if (flash_o.cs_n === 1'b0) begin
                cs_low <= 1'b1;
            end
        end
    end

    task automatic check_bit(input string what, input logic exp, input logic got);
        samples_checked++;
        if (got !== exp) begin
            mismatches++;
            $display("unexpected %s: expected %b, seen %b", what, exp, got);
        end
    endtask

    task automatic check_word(input string what, input logic [31:0] exp, input logic [31:0] got);
        samples_checked++;
        if (got !== exp) begin
            mismatches++;
            $display("unexpected %s: expected %h, seen %h", what, exp, got);
        end
    endtask

    task automatic stop_test();
        $display("checks %0d mismatches %0d", samples_checked, mismatches);
        if (mismatches == 0 && samples_checked > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask

    function automatic logic [31:0] crc_of(input int n);
        logic [31:0] c;
        c = `CRC_INIT;
        for (int i = 0; i < n; i++) begin
            c = c ^ {24'h00_0000, i_boot_mem_model.mem[i]};
            for (int j = 0; j < 8; j++) begin
                c = c[0] ? ((c >> 1) ^ `CRC_POLY) : (c >> 1);
            end
        end
        return ~c;
    endfunction

    task automatic put(input int a, input logic [31:0] w);
        for (int b = 0; b < 4; b++) begin
            i_boot_mem_model.mem[a + b] = w[8 * b +: 8];
        end
    endtask

    // Check kind: 0 good checksum, 1 bypass word, 2 corrupted checksum
    task automatic build(input int nw, input int kind);
        logic [31:0] c;
        for (int k = 0; k < 64; k++) begin
            i_boot_mem_model.mem[k] = 8'hA5 ^ k[7:0];
        end
        put(0, nw);
        for (int i = 0; i < nw; i++) begin
            prog[i] = 32'h1357_9BDF ^ (i * 32'h0102_0408);
            put(4 + 4 * i, prog[i]);
        end
        c = crc_of(4 + 4 * nw);
        if (kind == 1) c = `BYPASS_WORD;
        if (kind == 2) c = c ^ 32'h0000_0001;
        put(4 + 4 * nw, c);
    endtask

    task automatic boot(input logic sec);
        int n;
        @(posedge ref_clk_i);
        rst_i <= 1'b1;
        rst_pin_n_i <= 1'b0;
        // The two sources differ in every bit: OTP sets only bit 5, flash sets all bits except bit 5
        security_word_i <= sec ? 32'h0000_0020 : 32'hFFFF_FFDF;
        repeat (6) @(posedge ref_clk_i);
        rst_i <= 1'b0;
        repeat (10) @(posedge ref_clk_i);
        #1;
        check_bit("pull-down in reset", 1'b1, gpio_pull_down_o);
        check_bit("idle in reset", 1'b1, flash_o.cs_n & ~otp_rd_o & ~run_o);
        @(posedge ref_clk_i);
        rst_pin_n_i <= 1'b1;
        n = 0;
        while (n < 30000 && flash_o.cs_n !== 1'b0 && otp_rd_o !== 1'b1) begin
            @(posedge ref_clk_i);
            #1;
            n++;
        end
        check_bit("boot delay", 1'b1, n >= SEQ && n <= SEQ + 8);
        if (n >= 30000) begin
            stop_test();
        end
        n = 0;
        while (n < 30000 && run_o !== 1'b1 && boot_error_o !== 1'b1) begin
            @(posedge ref_clk_i);
            #1;
            n++;
        end
        if (n >= 30000) begin
            check_bit("boot finished", 1'b1, 1'b0);
            stop_test();
        end
        check_bit("pull-down after reset", 1'b0, gpio_pull_down_o);
    endtask

    task automatic check_ram(input int nw);
        check_word("ram write count", nw, n_wr);
        for (int i = 0; i < nw; i++) begin
            check_word("ram address", i, wr_addr[i]);
            check_word("ram data", prog[i], wr_data[i]);
        end
    endtask

    task automatic t_flash_crc();
        build(3, 0);
        boot(1'b0);
        check_ram(3);
        check_word("flash command", {`FLASH_READ_CMD, `FLASH_START_ADDR}, cmd);
        check_word("otp reads", 0, otp_reads);
        check_bit("run", 1'b1, run_o);
        check_word("start address", `RAM_BASE, start_addr_o);
    endtask

    task automatic t_flash_bypass();
        build(2, 1);
        boot(1'b0);
        check_ram(2);
        check_bit("run", 1'b1, run_o);
        check_bit("boot error", 1'b0, boot_error_o);
    endtask

    task automatic t_flash_bad();
        build(1, 2);
        boot(1'b0);
        repeat (20) @(posedge ref_clk_i);
        #1;
        check_bit("boot error", 1'b1, boot_error_o);
        check_bit("run", 1'b0, run_o);
    endtask

    task automatic t_otp_crc();
        build(2, 0);
        boot(1'b1);
        check_ram(2);
        check_bit("run", 1'b1, run_o);
        check_word("first otp row", 32'h0000_0000, {21'h00_0000, otp_first});
        check_bit("flash selected", 1'b0, cs_low);
    endtask

    task automatic t_otp_empty();
        build(0, 0);
        boot(1'b1);
        check_ram(0);
        check_bit("run", 1'b1, run_o);
    endtask

    initial begin
        rst_i = 1'b1;
        rst_pin_n_i = 1'b0;
        security_word_i = 32'h0000_0000;
        mismatches = 0;
        samples_checked = 0;
        repeat (6) @(posedge ref_clk_i);
        t_flash_crc();
        t_flash_bypass();
        t_flash_bad();
        t_otp_crc();
        t_otp_empty();
        stop_test();
    end
endmodule
